// file: hdl/fsli_pkg.sv
// Register map, field positions and reset values of the framer status and control block
package fsli_pkg;
  // Register offsets on the parallel port
  localparam logic [7:0] ADDR_SR1 = 8'h06;
  localparam logic [7:0] ADDR_SR2 = 8'h07;
  localparam logic [7:0] ADDR_RIR = 8'h08;
  localparam logic [7:0] ADDR_INTERRUPT_MASK_ONE = 8'h16;
  localparam logic [7:0] ADDR_INTERRUPT_MASK_TWO = 8'h17;
  localparam logic [7:0] ADDR_CCR = 8'h1d;
  localparam logic [7:0] ADDR_SYNC = 8'h1e;
  // Control register fields
  localparam int TX_SRC_BIT = 2;
  localparam int RX_RST_BIT = 1;
  localparam int TX_RST_BIT = 0;
  localparam logic [7:0] CCR_USED = 8'h07;
  localparam logic [7:0] CCR_RESET = 8'h00;
  localparam logic [7:0] IMR_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  // Status one: bits that follow a persisting alarm, and the four change-interrupt alarms
  localparam logic [7:0] SR1_LEVEL_BITS = 8'hef;
  localparam logic [7:0] SR1_CHANGE_BITS = 8'h0f;
  // Index of each latched register in the local arrays
  localparam int NUM_LATCHED = 3;
  localparam logic [1:0] IDX_SR1 = 2'h0;
  localparam logic [1:0] IDX_SR2 = 2'h1;
  localparam logic [1:0] IDX_RIR = 2'h2;
  localparam logic [1:0] IDX_NONE = 2'h3;
endpackage

// file: hdl/fsli_top.sv
// Per-framer control register, latched status registers and interrupt output
// Behaviour
// RQ1: Software writes zero to the five unused upper control bits.
// RQ2: Source bit 0 selects transmit pin clock and loss mux; 1 selects receive clock.
// RQ3: Rising receive store reset bit forces receive store to one-frame depth.
// RQ4: Rising transmit store reset bit forces transmit store to one-frame depth.
// RQ5: Software pulses store resets after system clocks are stable, then clears them.
// RQ6: Status bits latch to one on event or alarm until read.
// RQ7: Read clears a bit; alarm bits stay set while alarm persists.
// RQ8: Write is a mask: ones refresh readable copy, zeros hold it.
// RQ9: Software writes mask, reads, then writes back read AND mask.
// RQ10: Synchronizer status is read-only, live, needs no mask write.
// RQ11: Each status bit drives interrupt only when its mask bit is set.
// RQ12: Four level alarms raise interrupt on every change of state.
// RQ13: Alarm interrupt releases when its bit is read; bit stays while alarm.
// RQ14: Event interrupt raised on event, released when its bit is read.
// RQ15: Interrupt output is inverse OR of all unmasked pending requests.
// RQ16: An event in the clearing cycle keeps its bit set.
`timescale 1ns/1ps
module fsli_top (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic [7:0] status_one_src,
  input wire logic [7:0] status_two_src,
  input wire logic [7:0] receive_information_src,
  input wire logic [7:0] synchronizer_live_status,
  input wire logic hdlc_irq_req,
  output logic int_n,
  output logic transmit_clock_source_select,
  output logic transmit_clock_loss_mux_en,
  output logic receive_store_reset,
  output logic transmit_store_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta_n;
  logic rst_n;

  // Two stages so release is clean against mclk
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  // Map an address onto a latched register index
  function automatic logic [1:0] latched_index(input logic [7:0] a);
    case (a)
      fsli_pkg::ADDR_SR1: latched_index = fsli_pkg::IDX_SR1;
      fsli_pkg::ADDR_SR2: latched_index = fsli_pkg::IDX_SR2;
      fsli_pkg::ADDR_RIR: latched_index = fsli_pkg::IDX_RIR;
      default: latched_index = fsli_pkg::IDX_NONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [7:0] latched [fsli_pkg::NUM_LATCHED];
  logic [7:0] readable [fsli_pkg::NUM_LATCHED];
  logic [7:0] read_mask [fsli_pkg::NUM_LATCHED];
  logic [7:0] next_latched [fsli_pkg::NUM_LATCHED];
  logic [7:0] next_readable [fsli_pkg::NUM_LATCHED];
  logic [7:0] next_read_mask [fsli_pkg::NUM_LATCHED];
  logic [7:0] alarm_prev;
  logic [7:0] alarm_change;
  logic [7:0] next_alarm_prev;
  logic [7:0] next_alarm_change;
  logic [7:0] imr_one;
  logic [7:0] imr_two;
  logic [7:0] next_imr_one;
  logic [7:0] next_imr_two;
  logic [7:0] ccr;
  logic [7:0] next_ccr;
  logic [7:0] next_rdata;
  logic next_int_n;
  logic next_tx_src;
  logic next_loss_mux_en;
  logic next_rx_rst;
  logic next_tx_rst;
  logic [7:0] event_req;
  logic [7:0] next_event_req;
  logic [1:0] acc_idx;
  logic sr1_read;

  logic [7:0] src [fsli_pkg::NUM_LATCHED];
  assign src[fsli_pkg::IDX_SR1] = status_one_src;
  assign src[fsli_pkg::IDX_SR2] = status_two_src;
  assign src[fsli_pkg::IDX_RIR] = receive_information_src;

  ////////////////////////////////////////////////////////////////////////////
  // Host access decode

  // One shared decode keeps the latched registers and the status one requests agreeing on the target
  assign acc_idx = latched_index(addr);
  // RQ13: status one read
  assign sr1_read = rd_stb && (acc_idx == fsli_pkg::IDX_SR1);

  ////////////////////////////////////////////////////////////////////////////
  // Latched status registers

  // Latch, read-clear and mask write of all three latched registers
  // The readable copy moves only on a mask write, never on an event
  always_comb begin
    for (int k = 0; k < fsli_pkg::NUM_LATCHED; k++) begin
      next_latched[k] = latched[k];
      next_readable[k] = readable[k];
      next_read_mask[k] = read_mask[k];
      // RQ7: read clears reported bits
      // Only bits both asked for and shown are cleared; unseen ones survive
      if (rd_stb && acc_idx == k[1:0]) begin
        next_latched[k] = latched[k] & ~(read_mask[k] & readable[k]);
      end
      // RQ16: set wins over clear
      // RQ6: latch on event
      // A persisting alarm sets its bit again every cycle
      next_latched[k] = next_latched[k] | src[k];
      // RQ8: mask write refreshes selected bits only
      if (wr_stb && acc_idx == k[1:0]) begin
        next_readable[k] = (readable[k] & ~wdata) | (latched[k] & wdata);
        next_read_mask[k] = wdata;
      end
    end
  end

  // Latched registers, all clear out of reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < fsli_pkg::NUM_LATCHED; k++) begin
        latched[k] <= fsli_pkg::LATCH_RESET;
        readable[k] <= fsli_pkg::LATCH_RESET;
        read_mask[k] <= fsli_pkg::LATCH_RESET;
      end
    end else begin
      for (int k = 0; k < fsli_pkg::NUM_LATCHED; k++) begin
        latched[k] <= next_latched[k];
        readable[k] <= next_readable[k];
        read_mask[k] <= next_read_mask[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt requests of status one

  // Change detect on four level alarms, rising edge on the rest
  // Edge based, so a persisting alarm can still be acknowledged
  // Limitation: a source held high counts as one event only
  always_comb begin
    logic [7:0] rise;
    logic [7:0] chg;
    // RQ14: request on rising edge
    rise = status_one_src & ~alarm_prev & ~fsli_pkg::SR1_CHANGE_BITS;
    // RQ12: change detect on the four level alarms
    chg = (status_one_src ^ alarm_prev) & fsli_pkg::SR1_CHANGE_BITS;
    next_alarm_prev = status_one_src;
    next_alarm_change = alarm_change;
    next_event_req = event_req;
    // RQ13: reading the alarm bit releases its request
    if (sr1_read) begin
      next_alarm_change = alarm_change & ~read_mask[fsli_pkg::IDX_SR1];
    end
    // RQ14: reading the event bit releases its request
    if (sr1_read) begin
      next_event_req = event_req & ~read_mask[fsli_pkg::IDX_SR1];
    end
    // A fresh edge in the read cycle wins over the release
    next_alarm_change = next_alarm_change | chg;
    next_event_req = next_event_req | rise;
  end

  // Request registers; a source high at reset release counts as a change
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_prev <= fsli_pkg::LATCH_RESET;
      alarm_change <= fsli_pkg::LATCH_RESET;
      event_req <= fsli_pkg::LATCH_RESET;
    end else begin
      alarm_prev <= next_alarm_prev;
      alarm_change <= next_alarm_change;
      event_req <= next_event_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mask and control registers

  // Host writes outside the latched set
  always_comb begin
    next_imr_one = imr_one;
    next_imr_two = imr_two;
    next_ccr = ccr;
    if (wr_stb) begin
      case (addr)
        fsli_pkg::ADDR_INTERRUPT_MASK_ONE: next_imr_one = wdata;
        fsli_pkg::ADDR_INTERRUPT_MASK_TWO: next_imr_two = wdata;
        // Unused upper bits are dropped whatever software sends
        fsli_pkg::ADDR_CCR: next_ccr = wdata & fsli_pkg::CCR_USED;
        default: next_ccr = ccr;
      endcase
    end
  end

  // Masks start at zero so no status bit interrupts before software opts in; the hdlc request is unmasked
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      imr_one <= fsli_pkg::IMR_RESET;
      imr_two <= fsli_pkg::IMR_RESET;
      ccr <= fsli_pkg::CCR_RESET;
    end else begin
      imr_one <= next_imr_one;
      imr_two <= next_imr_two;
      ccr <= next_ccr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  // Read data path; unmapped addresses read zero
  // Held between reads so a slow host may sample late
  always_comb begin
    next_rdata = rdata;
    if (rd_stb) begin
      case (addr)
        fsli_pkg::ADDR_SR1: next_rdata = readable[fsli_pkg::IDX_SR1];
        fsli_pkg::ADDR_SR2: next_rdata = readable[fsli_pkg::IDX_SR2];
        fsli_pkg::ADDR_RIR: next_rdata = readable[fsli_pkg::IDX_RIR];
        fsli_pkg::ADDR_INTERRUPT_MASK_ONE: next_rdata = imr_one;
        fsli_pkg::ADDR_INTERRUPT_MASK_TWO: next_rdata = imr_two;
        fsli_pkg::ADDR_CCR: next_rdata = ccr;
        // RQ10: live synchronizer status, unlatched
        fsli_pkg::ADDR_SYNC: next_rdata = synchronizer_live_status;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pin and control outputs

  // Outputs follow the next state so they move on the same edge
  // Costs a longer path, but saves a cycle of interrupt latency
  always_comb begin
    logic [7:0] pend;
    // RQ14: event requests pending
    pend = next_event_req;
    // RQ13: alarm requests until read
    pend = pend | next_alarm_change;
    // RQ11: mask gating per source
    // RQ15: active-low OR of all requests
    next_int_n = ~(|(pend & next_imr_one) |
                   |(next_latched[fsli_pkg::IDX_SR2] & next_imr_two) |
                   hdlc_irq_req);
    // RQ2: formatter clock source and loss mux
    next_tx_src = next_ccr[fsli_pkg::TX_SRC_BIT];
    next_loss_mux_en = ~next_ccr[fsli_pkg::TX_SRC_BIT];
    // RQ3: receive store reset on rising bit
    next_rx_rst = next_ccr[fsli_pkg::RX_RST_BIT] & ~ccr[fsli_pkg::RX_RST_BIT];
    // RQ4: transmit store reset on rising bit
    next_tx_rst = next_ccr[fsli_pkg::TX_RST_BIT] & ~ccr[fsli_pkg::TX_RST_BIT];
  end

  // Outputs straight from flops; idle levels while in reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_n <= 1'b1;
      transmit_clock_source_select <= 1'b0;
      transmit_clock_loss_mux_en <= 1'b1;
      receive_store_reset <= 1'b0;
      transmit_store_reset <= 1'b0;
    end else begin
      int_n <= next_int_n;
      transmit_clock_source_select <= next_tx_src;
      transmit_clock_loss_mux_en <= next_loss_mux_en;
      receive_store_reset <= next_rx_rst;
      transmit_store_reset <= next_tx_rst;
    end
  end

endmodule

// file: tb/fsli_checker.sv
// Port-level checks for the framer status, control and interrupt block
`timescale 1ns/1ps
module fsli_checker (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  input wire logic [7:0] status_one_src,
  input wire logic [7:0] status_two_src,
  input wire logic [7:0] receive_information_src,
  input wire logic [7:0] synchronizer_live_status,
  input wire logic hdlc_irq_req,
  input wire logic int_n,
  input wire logic transmit_clock_source_select,
  input wire logic transmit_clock_loss_mux_en,
  input wire logic receive_store_reset,
  input wire logic transmit_store_reset
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  AST_MUX_INV: assert property (
    transmit_clock_loss_mux_en == !transmit_clock_source_select)
    else $error("loss mux enable not inverse of source select");
  AST_CCR_READ: assert property (
    rd_stb && addr == fsli_pkg::ADDR_CCR |=>
    rdata[7:2] == {5'h00, $past(transmit_clock_source_select)})
    else $error("control read disagrees with source select");
  AST_RX_PULSE: assert property (receive_store_reset |=> !receive_store_reset)
    else $error("receive store reset longer than one cycle");
  AST_TX_PULSE: assert property (transmit_store_reset |=> !transmit_store_reset)
    else $error("transmit store reset longer than one cycle");
  // A store reset pulse only follows a host write
  AST_RX_CAUSE: assert property (
    $rose(receive_store_reset) |-> $past(wr_stb) || $past(wr_stb, 2))
    else $error("receive store reset without a write");
  AST_TX_CAUSE: assert property (
    $rose(transmit_store_reset) |-> $past(wr_stb) || $past(wr_stb, 2))
    else $error("transmit store reset without a write");
  AST_SYNC_LIVE: assert property (
    rd_stb && addr == fsli_pkg::ADDR_SYNC |=> rdata == $past(synchronizer_live_status))
    else $error("synchronizer read not live");
  AST_HDLC_INT: assert property (hdlc_irq_req |=> !int_n)
    else $error("hdlc request did not pull interrupt low");
  // Release needs a host access or a dropped hdlc request
  AST_INT_RELEASE: assert property (
    $rose(int_n) |-> $past(rd_stb) || $past(rd_stb, 2) || $past(wr_stb) ||
    $past(wr_stb, 2) || $past(hdlc_irq_req, 2))
    else $error("interrupt released without cause");
endmodule
bind fsli_top fsli_checker chk_i (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .status_one_src(status_one_src),
  .status_two_src(status_two_src), .receive_information_src(receive_information_src),
  .synchronizer_live_status(synchronizer_live_status), .hdlc_irq_req(hdlc_irq_req),
  .int_n(int_n), .transmit_clock_source_select(transmit_clock_source_select),
  .transmit_clock_loss_mux_en(transmit_clock_loss_mux_en),
  .receive_store_reset(receive_store_reset), .transmit_store_reset(transmit_store_reset));

// file: tb/fsli_mcu.sv
// Host processor model driving the parallel register port
`timescale 1ns/1ps
module fsli_mcu (
  input wire logic mclk,
  input wire logic [7:0] rdata,
  output logic [7:0] addr = 8'h00,
  output logic [7:0] wdata = 8'h00,
  output logic wr_stb = 1'b0,
  output logic rd_stb = 1'b0
);
  ////////////////////////////////////////////////////////////////////////////////
  // One access; data line scrambled once released so stale values never help
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
    @(negedge mclk);
    addr = a;
    wdata = (a == fsli_pkg::ADDR_CCR) ? (d & fsli_pkg::CCR_USED) : d;
    wr_stb = w;
    rd_stb = !w;
    @(negedge mclk);
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    wdata = ~wdata;
    @(negedge mclk);
    q = rdata;
  endtask
  task automatic poll(input logic [7:0] a, input logic [7:0] m, output logic [7:0] q);
    logic [7:0] z;
    acc(1'b1, a, m, z);
    acc(1'b0, a, 8'h00, q);
    acc(1'b1, a, q & m, z);
  endtask
endmodule

// file: tb/fsli_top_bench.sv
// Self-checking bench for the framer status, control and interrupt block
`timescale 1ns/1ps
module fsli_top_bench;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] s1 = 8'h00, s2 = 8'h00, ri = 8'h00, sync = 8'ha5;
  logic hreq = 1'b0;
  logic [7:0] rdata, addr, wdata;
  logic wr_stb, rd_stb, int_n, sel, muxen, rxr, txr;
  int n_mismatch = 0, check_count = 0, rx_cnt = 0, tx_cnt = 0;
  fsli_top dut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .status_one_src(s1), .status_two_src(s2),
    .receive_information_src(ri), .synchronizer_live_status(sync), .hdlc_irq_req(hreq),
    .int_n(int_n), .transmit_clock_source_select(sel), .transmit_clock_loss_mux_en(muxen),
    .receive_store_reset(rxr), .transmit_store_reset(txr));
  fsli_mcu mcu (.mclk(mclk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, store pulse counters and hang guard
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) begin
    rx_cnt <= rx_cnt + int'(rxr);
    tx_cnt <= tx_cnt + int'(txr);
  end
  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Control register: reset value, source select, both store resets at once
  task automatic t_ctrl();
    logic [7:0] q;
    chk({4'h0, int_n, sel, muxen, rxr | txr}, 8'h0a);
    mcu.acc(1'b0, fsli_pkg::ADDR_CCR, 8'h00, q);
    chk(q, fsli_pkg::CCR_RESET);
    mcu.acc(1'b1, fsli_pkg::ADDR_CCR, 8'h04, q);
    mcu.acc(1'b0, fsli_pkg::ADDR_CCR, 8'h00, q);
    chk(q, 8'h04);
    chk({6'h00, sel, muxen}, 8'h02);
    mcu.acc(1'b1, fsli_pkg::ADDR_CCR, 8'h07, q);
    mcu.acc(1'b1, fsli_pkg::ADDR_CCR, 8'h00, q);
    chk({rx_cnt[3:0], tx_cnt[3:0]}, 8'h11);
    chk({6'h00, sel, muxen}, 8'h01);
  endtask
  // Event interrupt and mask-hold behaviour
  task automatic t_event();
    logic [7:0] q;
    mcu.acc(1'b1, fsli_pkg::ADDR_INTERRUPT_MASK_TWO, 8'h01, q);
    mcu.acc(1'b0, fsli_pkg::ADDR_INTERRUPT_MASK_TWO, 8'h00, q);
    chk(q, 8'h01);
    s2 = 8'h01;
    ri = 8'h08;
    settle(1);
    s2 = 8'h00;
    ri = 8'h00;
    settle(1);
    chk({7'h00, int_n}, 8'h00);
    mcu.poll(fsli_pkg::ADDR_SR2, 8'h01, q);
    chk(q, 8'h01);
    chk({7'h00, int_n}, 8'h01);
    mcu.poll(fsli_pkg::ADDR_SR2, 8'h01, q);
    chk(q, 8'h00);
    mcu.poll(fsli_pkg::ADDR_RIR, 8'h00, q);
    chk(q, 8'h00);
    mcu.poll(fsli_pkg::ADDR_RIR, 8'h08, q);
    chk(q, 8'h08);
  endtask
  // Level alarm: both edges interrupt, bit persists, masked alarm stays quiet
  task automatic t_alarm();
    logic [7:0] q;
    mcu.acc(1'b1, fsli_pkg::ADDR_INTERRUPT_MASK_ONE, 8'h01, q);
    mcu.acc(1'b0, fsli_pkg::ADDR_INTERRUPT_MASK_ONE, 8'h00, q);
    chk(q, 8'h01);
    s1 = 8'h01;
    settle(2);
    chk({7'h00, int_n}, 8'h00);
    mcu.poll(fsli_pkg::ADDR_SR1, 8'h01, q);
    chk(q, 8'h01);
    chk({7'h00, int_n}, 8'h01);
    mcu.poll(fsli_pkg::ADDR_SR1, 8'h01, q);
    chk(q, 8'h01);
    s1 = 8'h00;
    settle(2);
    chk({7'h00, int_n}, 8'h00);
    mcu.poll(fsli_pkg::ADDR_SR1, 8'h01, q);
    s1 = 8'h02;
    settle(2);
    chk({7'h00, int_n}, 8'h01);
    // Persisting non-level alarm: one request, released by its read
    mcu.acc(1'b1, fsli_pkg::ADDR_INTERRUPT_MASK_ONE, 8'h80, q);
    s1 = 8'h82;
    settle(2);
    chk({7'h00, int_n}, 8'h00);
    mcu.poll(fsli_pkg::ADDR_SR1, 8'h80, q);
    chk(q, 8'h80);
    chk({7'h00, int_n}, 8'h01);
  endtask
  // Live synchronizer reads, unmapped read, external hdlc request
  task automatic t_misc();
    logic [7:0] q;
    mcu.acc(1'b0, fsli_pkg::ADDR_SYNC, 8'h00, q);
    chk(q, 8'ha5);
    sync = 8'h3c;
    mcu.acc(1'b0, fsli_pkg::ADDR_SYNC, 8'h00, q);
    chk(q, 8'h3c);
    mcu.acc(1'b0, 8'h00, 8'h00, q);
    chk(q, 8'h00);
    hreq = 1'b1;
    settle(2);
    chk({7'h00, int_n}, 8'h00);
    hreq = 1'b0;
    settle(2);
    chk({7'h00, int_n}, 8'h01);
  endtask
  initial begin
    settle(5);
    nrst = 1'b1;
    settle(3);
    t_ctrl();
    t_event();
    t_alarm();
    t_misc();
    end_sim();
  end
endmodule
